/* File: hw/smrb_device.sv */
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "smrb_defs.svh"
module smrb_device
  import smrb_pkg::*;
#(
  parameter int WD_TICK_CYC = `WD_TICK_MS * `CLK_KHZ,
  parameter int ADC_PERSIST_CYC = `ADC_PERSIST_MS * `CLK_KHZ,
  parameter int ADC_REFRESH_CYC = `ADC_REFRESH_MS * `CLK_KHZ
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  smrb_link_if.dev lk,
  // Monitored conditions
  input wire logic [7:0] adc_sample,
  input wire logic over_temp_in,
  input wire logic primary_gp_input_pin,
  // Controls
  output logic primary_gp_output_pin,
  output logic [7:0] margin_12,
  output logic [7:0] margin_34,
  output logic wd_expired
);
  logic [2:0] clk_sy_r;
  logic [17:0] req_s1_r, req_s2_r;
  logic [7:0] adc_s1_r, adc_s2_r;
  logic [1:0] ot_sy_r, gpi_sy_r;
  logic rise, wr_acc, rd_acc;
  logic [7:0] addr, wdata, rd_val;
  byte_t imask_r, devctl_r, wdto_r, adcth_r, adc_reg_r, rdata_r;
  byte_t cause_r;
  logic [3:0] wd_cfg_r, wd_stage_r;
  logic wd_svc_r, last04_r, wd_load, wd_enable_key, wd_service_key;
  logic [7:0] wd_cnt_r;
  logic [31:0] tick_r, persist_r, refresh_r;
  logic wd_expire, adc_al_r, ot_prev_r, adc_al_prev_r;
  logic [7:0] cause_set;
  logic int_pend_r;

  // Link inputs cross in two flip-flops; request words are held still
  // for half a link period around the edge, so bitwise sync is safe.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sy_r <= 3'h0;
      req_s1_r <= 18'h0_0000;
      req_s2_r <= 18'h0_0000;
      adc_s1_r <= `RST_BYTE;
      adc_s2_r <= `RST_BYTE;
      ot_sy_r <= 2'h0;
      gpi_sy_r <= 2'h0;
    end else begin
      clk_sy_r <= {clk_sy_r[1:0], lk.lk_clk};
      req_s1_r <= {lk.lk_sel, lk.lk_wr, lk.lk_addr, lk.lk_wdata};
      req_s2_r <= req_s1_r;
      adc_s1_r <= adc_sample;
      adc_s2_r <= adc_s1_r;
      ot_sy_r <= {ot_sy_r[0], over_temp_in};
      gpi_sy_r <= {gpi_sy_r[0], primary_gp_input_pin};
    end
  end

  assign rise = clk_sy_r[1] & ~clk_sy_r[2];
  assign addr = req_s2_r[15:8];
  assign wdata = req_s2_r[7:0];
  assign wr_acc = rise & req_s2_r[17] & req_s2_r[16];
  assign rd_acc = rise & req_s2_r[17] & ~req_s2_r[16];

  assign wd_enable_key = wr_acc && addr == `REG_ALARM &&
                         wdata == `KEY_ENABLE && last04_r &&
                         !wd_cfg_r[`WD_EN];
  assign wd_service_key = wr_acc && addr == `REG_ALARM &&
                          wdata == `KEY_SERVICE && last04_r &&
                          wd_svc_r && wd_cfg_r[`WD_EN];

  // Plain read/write registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_r <= `RST_BYTE;
      devctl_r <= `RST_BYTE;
      wdto_r <= `RST_WDTO;
      adcth_r <= `RST_BYTE;
      margin_12 <= `RST_BYTE;
      margin_34 <= `RST_BYTE;
    end else if (wr_acc) begin
      case (addr)
        `REG_IMASK: imask_r <= wdata & `IMASK_WMASK;
        `REG_DEVCTL: devctl_r <= wdata & `DEVCTL_WMASK;
        `REG_WDTO: wdto_r <= wdata;
        `REG_ADCTH: adcth_r <= wdata;
        `REG_MARG12: begin
          margin_12 <= {wdata[7:3], (wdata[2:0] <= `M1_MAX_CODE) ?
                        wdata[2:0] : margin_12[2:0]} & `MARG12_WMASK;
        end
        `REG_MARG34: margin_34 <= wdata & `MARG34_WMASK;
        default: ;
      endcase
    end
  end

  // Watchdog staging; alarm register itself has no storage to alter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cfg_r <= 4'h0;
      wd_stage_r <= 4'h0;
      wd_svc_r <= 1'b0;
      last04_r <= 1'b0;
    end else if (wr_acc) begin
      last04_r <= addr == `REG_WDCTL;
      if (addr == `REG_WDCTL) begin
        wd_svc_r <= wdata[`WD_SVC];
        if (!wd_cfg_r[`WD_EN]) begin
          wd_stage_r <= wdata[4:1];
        end
      end
      if (wd_enable_key) begin
        wd_cfg_r <= wd_stage_r;
      end
      if (wd_service_key) begin
        wd_svc_r <= 1'b0;
      end
    end
  end

  // Countdown in 125 ms ticks; a new count waits for a reload point
  assign wd_load = wd_enable_key | wd_service_key;
  assign wd_expire = wd_cfg_r[`WD_EN] && tick_r == 32'(WD_TICK_CYC - 1)
                     && wd_cnt_r <= 8'h01;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_r <= 32'h0000_0000;
      wd_cnt_r <= `RST_WDTO;
      wd_expired <= 1'b0;
    end else begin
      wd_expired <= wd_expire;
      if (wd_load) begin
        tick_r <= 32'h0000_0000;
        wd_cnt_r <= wdto_r;
      end else if (wd_cfg_r[`WD_EN]) begin
        if (tick_r == 32'(WD_TICK_CYC - 1)) begin
          tick_r <= 32'h0000_0000;
          // A zero count would expire on every tick
          wd_cnt_r <= wd_expire ? wdto_r : wd_cnt_r - 8'h01;
        end else begin
          tick_r <= tick_r + 32'h0000_0001;
        end
      end
    end
  end

  // ADC register refresh and threshold persistence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_r <= 32'h0000_0000;
      adc_reg_r <= `RST_BYTE;
    end else if (refresh_r == 32'(ADC_REFRESH_CYC - 1)) begin
      refresh_r <= 32'h0000_0000;
      adc_reg_r <= adc_s2_r;
    end else begin
      refresh_r <= refresh_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      persist_r <= 32'h0000_0000;
      adc_al_r <= 1'b0;
    end else if (adc_s2_r > adcth_r) begin
      if (persist_r == 32'(ADC_PERSIST_CYC - 1)) begin
        adc_al_r <= 1'b1;
      end else begin
        persist_r <= persist_r + 32'h0000_0001;
      end
    end else begin
      persist_r <= 32'h0000_0000;
      adc_al_r <= 1'b0;
    end
  end

  // Sticky causes: a new event wins over a clearing read
  always_comb begin
    cause_set = 8'h00;
    cause_set[`BIT_OTEMP] = ot_sy_r[1] & ~ot_prev_r &
                            imask_r[`BIT_OTEMP];
    cause_set[`BIT_ADCAL] = adc_al_r & ~adc_al_prev_r &
                            imask_r[`BIT_ADCAL];
    cause_set[`BIT_WDTO] = wd_expire & wd_cfg_r[`WD_IMSK];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ot_prev_r <= 1'b0;
      adc_al_prev_r <= 1'b0;
      cause_r <= `RST_BYTE;
      int_pend_r <= 1'b0;
    end else begin
      ot_prev_r <= ot_sy_r[1];
      adc_al_prev_r <= adc_al_r;
      if (rd_acc && addr == `REG_ICAUSE) begin
        cause_r <= cause_set;
      end else begin
        cause_r <= cause_r | cause_set;
      end
      int_pend_r <= devctl_r[`BIT_GIE] && cause_r != 8'h00 &&
                    !(rd_acc && addr == `REG_ICAUSE);
    end
  end

  assign lk.int_o = 1'b0;
  assign lk.int_oe = int_pend_r;
  assign primary_gp_output_pin = devctl_r[`BIT_GPO];

  always_comb begin
    rd_val = `RST_BYTE;
    case (addr)
      `REG_ALARM: begin
        rd_val[`BIT_OTEMP] = ot_sy_r[1];
        rd_val[`BIT_ADCAL] = adc_al_r;
      end
      `REG_IMASK: rd_val = imask_r;
      `REG_ICAUSE: rd_val = cause_r;
      `REG_WDCTL: rd_val = {3'h0, wd_cfg_r, wd_svc_r};
      `REG_DEVCTL: begin
        rd_val = devctl_r;
        rd_val[`BIT_GPI] = gpi_sy_r[1];
      end
      `REG_WDTO: rd_val = wdto_r;
      `REG_ADC: rd_val = adc_reg_r;
      `REG_ADCTH: rd_val = adcth_r;
      `REG_MARG12: rd_val = margin_12;
      `REG_MARG34: rd_val = margin_34;
      default: rd_val = `RST_BYTE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= `RST_BYTE;
    end else if (rd_acc) begin
      rdata_r <= rd_val;
    end
  end
  assign lk.lk_rdata = rdata_r;
endmodule // smrb_device
`default_nettype wire

/* File: hw/smrb_defs.svh */
`ifndef SMRB_DEFS_SVH
`define SMRB_DEFS_SVH
// Device register offsets
`define REG_ALARM 8'h00
`define REG_IMASK 8'h01
`define REG_ICAUSE 8'h02
`define REG_WDCTL 8'h04
`define REG_DEVCTL 8'h06
`define REG_WDTO 8'h07
`define REG_ADC 8'h08
`define REG_ADCTH 8'h09
`define REG_MARG12 8'h0e
`define REG_MARG34 8'h0f
// Unlock keys written to the alarm register
`define KEY_ENABLE 8'hbb
`define KEY_SERVICE 8'haa
// Field positions
`define BIT_OTEMP 6
`define BIT_ADCAL 5
`define BIT_WDTO 0
`define BIT_GIE 5
`define BIT_GPO 1
`define BIT_GPI 0
`define WD_EN 3
`define WD_IMSK 2
`define WD_SVC 0
// Writable bits
`define IMASK_WMASK 8'h7e
`define DEVCTL_WMASK 8'h72
`define MARG12_WMASK 8'hf7
`define MARG34_WMASK 8'h7f
`define M1_MAX_CODE 3'h4
// Reset values
`define RST_BYTE 8'h00
`define RST_WDTO 8'hff
// Times
`define CLK_KHZ 200_000
`define WD_TICK_MS 125
`define ADC_PERSIST_MS 3
`define ADC_REFRESH_MS 10
// Host side
`define LK_HALF_CYC 12
`define H_CMD 12'h000
`define H_STAT 12'h004
`define H_WR_BIT 16
`define H_BUSY_BIT 0
`define H_DONE_BIT 1
`define H_INT_BIT 2
`endif

/* File: hw/smrb_pkg.sv */
package smrb_pkg;
  typedef logic [7:0] byte_t;
  typedef enum {LK_IDLE, LK_SETUP, LK_HIGH, LK_LOW, LK_WAIT} lk_state_e;
endpackage

/* File: hw/smrb_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface smrb_link_if;
  logic lk_clk;
  logic lk_sel;
  logic lk_wr;
  logic [7:0] lk_addr;
  logic [7:0] lk_wdata;
  logic [7:0] lk_rdata;
  logic int_o;
  logic int_oe;
  logic int_line;
  // Open-drain line with pull-up
  assign int_line = int_oe ? int_o : 1'b1;
  modport host (output lk_clk, lk_sel, lk_wr, lk_addr, lk_wdata,
                input lk_rdata, int_line);
  modport dev (input lk_clk, lk_sel, lk_wr, lk_addr, lk_wdata,
               output lk_rdata, int_o, int_oe);
endinterface
`default_nettype wire

/* File: hw/smrb_host.sv */
`timescale 1ns/10ps
`default_nettype none
`include "smrb_defs.svh"
module smrb_host
  import smrb_pkg::*;
#(
  parameter int HALF_CYC = `LK_HALF_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link
  smrb_link_if.host lk
);
  lk_state_e st_r;
  logic [7:0] ph_r;
  logic [7:0] rd_s1_r, rd_s2_r, rdata_r;
  logic [1:0] int_sy_r;
  logic done_r, go, done_set, done_clr, apb_do;
  logic clk_r, sel_r, wr_r;
  logic [7:0] addr_r, wdata_r;

  assign apb_do = psel & penable & pready;
  assign go = apb_do && pwrite && paddr == `H_CMD && st_r == LK_IDLE;
  assign done_set = st_r == LK_WAIT && ph_r == 8'(HALF_CYC - 1);
  assign done_clr = apb_do && pwrite && paddr == `H_STAT &&
                    pwdata[`H_DONE_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_s1_r <= 8'h00;
      rd_s2_r <= 8'h00;
      int_sy_r <= 2'h3;
    end else begin
      rd_s1_r <= lk.lk_rdata;
      rd_s2_r <= rd_s1_r;
      int_sy_r <= {int_sy_r[0], lk.int_line};
    end
  end

  // One frame: setup low, high, low, then settle for the read answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= LK_IDLE;
      ph_r <= 8'h00;
      clk_r <= 1'b0;
      sel_r <= 1'b0;
      wr_r <= 1'b0;
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      rdata_r <= 8'h00;
    end else begin
      ph_r <= ph_r + 8'h01;
      case (st_r)
        LK_IDLE: begin
          ph_r <= 8'h00;
          if (go) begin
            st_r <= LK_SETUP;
            sel_r <= 1'b1;
            wr_r <= pwdata[`H_WR_BIT];
            addr_r <= pwdata[15:8];
            wdata_r <= pwdata[7:0];
          end
        end
        LK_SETUP, LK_HIGH, LK_LOW: begin
          if (ph_r == 8'(HALF_CYC - 1)) begin
            ph_r <= 8'h00;
            clk_r <= st_r == LK_SETUP;
            st_r <= st_r == LK_SETUP ? LK_HIGH :
                    st_r == LK_HIGH ? LK_LOW : LK_WAIT;
          end
        end
        LK_WAIT: begin
          sel_r <= 1'b0;
          if (done_set) begin
            rdata_r <= rd_s2_r;
            st_r <= LK_IDLE;
          end
        end
        default: st_r <= LK_IDLE;
      endcase
    end
  end

  assign lk.lk_clk = clk_r;
  assign lk.lk_sel = sel_r;
  assign lk.lk_wr = wr_r;
  assign lk.lk_addr = addr_r;
  assign lk.lk_wdata = wdata_r;

  // Completion flag: set wins over a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else begin
      done_r <= done_set | (done_r & ~done_clr);
    end
  end

  // One wait state so every APB output comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      if (paddr == `H_STAT && !pwrite) begin
        prdata <= {16'h0000, rdata_r, 5'h00, ~int_sy_r[1], done_r,
                   st_r != LK_IDLE};
      end else if (paddr == `H_CMD) begin
        pslverr <= pwrite && st_r != LK_IDLE;
      end else if (paddr != `H_STAT) begin
        pslverr <= 1'b1;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule // smrb_host
`default_nettype wire

/* File: verif/smrb_link_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module smrb_link_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  input wire logic lk_clk,
  input wire logic lk_sel,
  input wire logic lk_wr,
  input wire logic [7:0] lk_addr,
  input wire logic [7:0] lk_wdata,
  input wire logic [7:0] lk_rdata,
  // Interrupt wire
  input wire logic int_o,
  input wire logic int_oe,
  input wire logic int_line
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence cause_read;
    $rose(lk_clk) && lk_sel && !lk_wr && lk_addr == 8'h02;
  endsequence
  sequence one_clk_pulse;
    ##[11:13] $rose(lk_clk) ##[11:13] $fell(lk_clk);
  endsequence
  a_int_pull_low: assert property (int_oe |-> !int_o && !int_line)
    else $error("interrupt driven but line not low");
  a_cause_read_release: assert property (cause_read |-> ##[1:8] !int_oe)
    else $error("interrupt still driven after cause read");
  a_frame_clock_pulse: assert property ($rose(lk_sel) |-> one_clk_pulse)
    else $error("link clock pulse misplaced in frame");
  a_idle_clock_low: assert property (!lk_sel |-> !lk_clk)
    else $error("link clock moves outside a frame");
  a_frame_fields_hold: assert property (
    lk_sel && $past(lk_sel) |-> $stable({lk_wr, lk_addr, lk_wdata}))
    else $error("frame fields changed inside a frame");
  a_read_data_hold: assert property (
    !lk_sel || lk_wr |-> $stable(lk_rdata))
    else $error("read data changed outside a read frame");
  a_frame_gap_min: assert property ($fell(lk_sel) |-> !lk_sel [*8])
    else $error("frames too close together");
  a_select_after_clock: assert property (
    $fell(lk_clk) |-> lk_sel [*8] ##[5:7] !lk_sel)
    else $error("frame end misplaced after clock pulse");
endmodule // smrb_link_checker
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "smrb_defs.svh"
module tb;
  import smrb_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [7:0] adc_sample, margin_12, margin_34;
  logic over_temp, gp_in, gp_out, wd_exp, clk_d;
  int n_fail = 0, comparisons = 0, cyc = 0, t_last = 0, t_prev = 0;
  int t_key = 0, m1 = 0;
  smrb_link_if lk ();
  smrb_host i_smrb_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lk(lk));
  // Short counts keep the watchdog and ADC runs brief
  smrb_device #(.WD_TICK_CYC(50), .ADC_PERSIST_CYC(20),
    .ADC_REFRESH_CYC(30)) i_smrb_device (.pclk(pclk), .presetn(presetn),
    .lk(lk), .adc_sample(adc_sample), .over_temp_in(over_temp),
    .primary_gp_input_pin(gp_in), .primary_gp_output_pin(gp_out),
    .margin_12(margin_12), .margin_34(margin_34), .wd_expired(wd_exp));
  smrb_link_checker i_smrb_link_checker (.pclk(pclk), .presetn(presetn),
    .lk_clk(lk.lk_clk), .lk_sel(lk.lk_sel), .lk_wr(lk.lk_wr),
    .lk_addr(lk.lk_addr), .lk_wdata(lk.lk_wdata), .lk_rdata(lk.lk_rdata),
    .int_o(lk.int_o), .int_oe(lk.int_oe), .int_line(lk.int_line));
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    clk_d <= lk.lk_clk;
    if (wd_exp === 1'b1) begin
      t_prev <= t_last;
      t_last <= cyc;
    end
    if (lk.lk_clk && !clk_d && lk.lk_wr && lk.lk_addr == `REG_ALARM &&
        lk.lk_wdata == `KEY_SERVICE) begin
      t_key <= cyc;
    end
    if (cyc == 50000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] w,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= w;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One link frame, then wait for done and clear it
  task automatic link(logic wr, byte_t a, byte_t w, output byte_t r);
    logic [31:0] s;
    int n;
    apb(1'b1, `H_CMD, {15'h0000, wr, a, w}, s, err);
    n = 0;
    do begin
      apb(1'b0, `H_STAT, 32'h0000_0000, s, err);
      n++;
    end while (s[`H_DONE_BIT] !== 1'b1 && n < 200);
    chk("link_done", 32'(s[`H_DONE_BIT]), 1);
    r = s[15:8];
    apb(1'b1, `H_STAT, 32'h0000_0002, s, err);
  endtask
  task automatic wr(byte_t a, byte_t w);
    byte_t r;
    link(1'b1, a, w, r);
  endtask
  task automatic rd(byte_t a, byte_t exp, string nm);
    byte_t r;
    link(1'b0, a, 8'h00, r);
    chk(nm, 32'(r), 32'(exp));
  endtask
  task automatic wait_exp();
    int t0;
    t0 = t_last;
    repeat (20000) if (t_last == t0) @(posedge pclk);
    chk("wd_expiry", 32'(t_last != t0), 1);
  endtask
  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    adc_sample = 0;
    over_temp = 0;
    gp_in = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // A second command while a frame runs is refused and dropped
    apb(1'b1, `H_CMD, {16'h0000, `REG_WDTO, 8'h00}, rv, err);
    apb(1'b1, `H_CMD, {16'h0001, `REG_WDTO, 8'h55}, rv, err);
    chk("busy_err", 32'(err), 1);
    repeat (60) @(posedge pclk);
    apb(1'b0, `H_STAT, 32'h0000_0000, rv, err);
    chk("busy_keep", rv, {16'h0000, `RST_WDTO, 8'h02});
    apb(1'b1, `H_STAT, 32'h0000_0002, rv, err);
    rd(`REG_WDTO, `RST_WDTO, "wdto_reset");
    apb(1'b0, 12'h008, 32'h0000_0000, rv, err);
    chk("unmapped_err", 32'(err), 1);
    for (int c = 0; c < 8; c++) begin
      // Reserved bits and refused output 1 codes must not stick
      if (c <= 4) m1 = c;
      wr(`REG_MARG12, {1'b1, c[2:0], 1'b1, c[2:0]});
      wr(`REG_MARG34, {1'b1, c[2:0], 1'b1, c[2:0]});
      rd(`REG_MARG12, {1'b1, c[2:0], 1'b0, m1[2:0]}, "marg12");
      rd(`REG_MARG34, {1'b0, c[2:0], 1'b1, c[2:0]}, "marg34");
      chk("m12", 32'(margin_12), 32'({1'b1, c[2:0], 1'b0, m1[2:0]}));
      chk("m34", 32'(margin_34), 32'({1'b0, c[2:0], 1'b1, c[2:0]}));
    end
    wr(`REG_DEVCTL, 8'h02);
    chk("gp_out", 32'(gp_out), 1);
    gp_in <= 1'b1;
    rd(`REG_DEVCTL, 8'h03, "gp_in_hi");
    gp_in <= 1'b0;
    rd(`REG_DEVCTL, 8'h02, "gp_in_lo");
    wr(`REG_IMASK, 8'h60);
    wr(`REG_ADCTH, 8'h80);
    // Two short excursions together outlast the persistence count
    adc_sample <= 8'h81;
    repeat (14) @(posedge pclk);
    adc_sample <= 8'h10;
    repeat (4) @(posedge pclk);
    adc_sample <= 8'h81;
    repeat (14) @(posedge pclk);
    adc_sample <= 8'h10;
    rd(`REG_ICAUSE, 8'h00, "adc_short");
    adc_sample <= 8'hff;
    repeat (40) @(posedge pclk);
    rd(`REG_ALARM, 8'h20, "adc_alarm");
    rd(`REG_ADC, 8'hff, "adc_full");
    rd(`REG_ICAUSE, 8'h20, "adc_cause");
    wr(`REG_IMASK, 8'h40);
    adc_sample <= 8'h10;
    repeat (40) @(posedge pclk);
    adc_sample <= 8'hff;
    repeat (40) @(posedge pclk);
    rd(`REG_ICAUSE, 8'h00, "adc_masked");
    adc_sample <= 8'h10;
    repeat (40) @(posedge pclk);
    rd(`REG_ADC, 8'h10, "adc_low");
    rd(`REG_ALARM, 8'h00, "adc_gone");
    over_temp <= 1'b1;
    rd(`REG_ALARM, 8'h40, "alarm_ot");
    chk("int_gated", 32'(lk.int_line), 1);
    wr(`REG_DEVCTL, 8'h22);
    chk("int_low", 32'(lk.int_line), 0);
    rd(`REG_ICAUSE, 8'h40, "cause_ot");
    chk("int_free", 32'(lk.int_line), 1);
    rd(`REG_ICAUSE, 8'h00, "cause_clr");
    over_temp <= 1'b0;
    wr(`REG_DEVCTL, 8'h02);
    wr(`REG_WDTO, 8'h02);
    wr(`REG_WDCTL, 8'h18);
    rd(`REG_WDCTL, 8'h00, "wd_pending");
    wr(`REG_ALARM, `KEY_ENABLE);
    rd(`REG_WDCTL, 8'h18, "wd_commit");
    rd(`REG_ALARM, 8'h00, "alarm_key");
    wait_exp();
    wait_exp();
    chk("wd_period", t_last - t_prev, 100);
    rd(`REG_ICAUSE, 8'h01, "wd_cause");
    wait_exp();
    wr(`REG_WDTO, 8'h04);
    wait_exp();
    chk("wd_keep", t_last - t_prev, 100);
    wait_exp();
    chk("wd_new", t_last - t_prev, 200);
    wr(`REG_WDCTL, 8'h19);
    wr(`REG_ALARM, `KEY_SERVICE);
    wait_exp();
    chk("wd_service", 32'((t_last - t_key) inside {[200:208]}), 1);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
